// *** bfh_flash_model.sv ***
`timescale 1ns/1ns
module bfh_flash_model (
  input  wire bfh_pkg::bfh_ctl_t ctl,
  input  wire logic [19:0]       addr_pins,
  input  wire logic [7:0]        data_pins_o,
  output logic [7:0]             data_pins_i,
  output logic                   ready_busy_n
);
  logic [7:0] mem [256];
  logic [7:0] mode = 8'hFF;
  logic [7:0] last = 8'h00;
  logic       wr = 1'b0;
  initial ready_busy_n = 1'b1;
  always @(negedge ctl.powerdown_reset_n) begin
    mode = 8'hFF;
    wr = 1'b0;
  end
  // A write ends on whichever of strobe or select rises first.
  always @(posedge ctl.write_strobe_n or posedge ctl.chip_select_n) begin
    if (!(ctl.write_strobe_n && ctl.chip_select_n)) begin
      if (wr) begin
        mem[{addr_pins[19:16], addr_pins[3:0]}] = data_pins_o;
        wr = 1'b0;
        mode = 8'h70;
        ready_busy_n = 1'b0;
        ready_busy_n <= #300 1'b1;
      end else if (data_pins_o == 8'h40 || data_pins_o == 8'h10) begin
        wr = 1'b1;
      end else begin
        mode = data_pins_o;
      end
    end
  end
  // Released pins show the inverse of the last value, never a kind guess.
  always @* begin
    if (!ctl.chip_select_n && !ctl.output_gate_n && ctl.powerdown_reset_n) begin
      data_pins_i = (mode == 8'h70) ? {ready_busy_n, 7'h00} :
        mem[{addr_pins[19:16], addr_pins[3:0]}];
      last = data_pins_i;
    end else begin
      data_pins_i = ~last;
    end
  end
endmodule : bfh_flash_model

// *** bfh_host.sv ***
`timescale 1ns/1ns
module bfh_host #(
  parameter int PHASE        = bfh_pkg::PHASE_CYC,
  parameter int WAKE_READ    = 8,
  parameter int WAKE_WRITE   = 8
) (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic                        req_valid,
  input  wire bfh_pkg::bfh_req_t           req,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [bfh_pkg::DATA_W-1:0]       rsp_data,
  output logic                             dev_busy,
  output bfh_pkg::bfh_ctl_t                ctl,
  output logic [bfh_pkg::ADDR_W-1:0]       addr_pins,
  output logic [bfh_pkg::DATA_W-1:0]       data_pins_o,
  output logic                             data_pins_oe,
  input  wire logic [bfh_pkg::DATA_W-1:0]  data_pins_i,
  input  wire logic                        ready_busy_n
);

  //////////////////////////////////////////////////////////////////////////////
  // Local constants and state encoding.

  localparam int TMR_W    = 8;
  localparam int WAKE_CYC = (WAKE_READ > WAKE_WRITE) ? WAKE_READ : WAKE_WRITE;

  typedef enum logic [6:0] {
    BFH_IDLE  = 7'h01,
    BFH_SETUP = 7'h02,
    BFH_STRB  = 7'h04,
    BFH_HOLD  = 7'h08,
    BFH_POLL  = 7'h10,
    BFH_PD    = 7'h20,
    BFH_WAKE  = 7'h40
  } bfh_st_t;

  bfh_st_t                     st_r;
  bfh_pkg::bfh_req_t           req_r;
  logic                        second_r;
  logic                        req_ready_r;
  logic                        rsp_valid_r;
  logic [bfh_pkg::DATA_W-1:0]  rsp_data_r;
  logic                        dev_busy_r;
  bfh_pkg::bfh_ctl_t           ctl_r;
  logic [bfh_pkg::ADDR_W-1:0]  addr_r;
  logic [bfh_pkg::DATA_W-1:0]  dout_r;
  logic                        oe_r;
  logic                        rb_meta_r;
  logic                        rb_sync_r;
  logic [bfh_pkg::DATA_W-1:0]  dq_meta_r;
  logic [bfh_pkg::DATA_W-1:0]  dq_sync_r;
  logic                        tmr_load_r;
  logic [TMR_W-1:0]            tmr_cnt_r;
  logic                        tmr_done;
  logic                        take;
  logic                        cyc_read;
  logic                        last_cyc;

  //////////////////////////////////////////////////////////////////////////////
  // Command decoding.

  // Command byte of the first bus cycle; read array is the default, and a plain read writes none.
  function automatic logic [bfh_pkg::DATA_W-1:0] first_cmd(
    input bfh_pkg::bfh_op_t op
  );
    logic [bfh_pkg::DATA_W-1:0] cmd;
    cmd = bfh_pkg::CMD_READ_ARRAY;
    case (op)
      bfh_pkg::BFH_OP_ARRAY:   cmd = bfh_pkg::CMD_READ_ARRAY;
      bfh_pkg::BFH_OP_ID:      cmd = bfh_pkg::CMD_READ_ID;
      bfh_pkg::BFH_OP_STATUS:  cmd = bfh_pkg::CMD_READ_STAT;
      bfh_pkg::BFH_OP_CLEAR:   cmd = bfh_pkg::CMD_CLR_STAT;
      bfh_pkg::BFH_OP_ERASE:   cmd = bfh_pkg::CMD_ERASE;
      bfh_pkg::BFH_OP_WRITE:   cmd = bfh_pkg::CMD_WRITE;
      bfh_pkg::BFH_OP_SUSPEND: cmd = bfh_pkg::CMD_SUSPEND;
      bfh_pkg::BFH_OP_RESUME:  cmd = bfh_pkg::CMD_CONFIRM;
      bfh_pkg::BFH_OP_LBLOCK:  cmd = bfh_pkg::CMD_LOCK_SETUP;
      bfh_pkg::BFH_OP_LMASTER: cmd = bfh_pkg::CMD_LOCK_SETUP;
      bfh_pkg::BFH_OP_LCLEAR:  cmd = bfh_pkg::CMD_LOCK_SETUP;
      default:                 cmd = bfh_pkg::CMD_READ_ARRAY;
    endcase
    return cmd;
  endfunction : first_cmd

  // Byte of the second bus cycle of a two-cycle sequence.
  function automatic logic [bfh_pkg::DATA_W-1:0] second_cmd(
    input bfh_pkg::bfh_op_t           op,
    input logic [bfh_pkg::DATA_W-1:0] data
  );
    logic [bfh_pkg::DATA_W-1:0] cmd;
    cmd = data;
    case (op)
      bfh_pkg::BFH_OP_ERASE:   cmd = bfh_pkg::CMD_CONFIRM;
      bfh_pkg::BFH_OP_LBLOCK:  cmd = bfh_pkg::CMD_SET_BLOCK;
      bfh_pkg::BFH_OP_LMASTER: cmd = bfh_pkg::CMD_SET_MASTER;
      bfh_pkg::BFH_OP_LCLEAR:  cmd = bfh_pkg::CMD_CONFIRM;
      default:                 cmd = data;
    endcase
    return cmd;
  endfunction : second_cmd

  function automatic logic has_second(input bfh_pkg::bfh_op_t op);
    return op inside {bfh_pkg::BFH_OP_STATUS, bfh_pkg::BFH_OP_ERASE,
                      bfh_pkg::BFH_OP_WRITE, bfh_pkg::BFH_OP_LBLOCK,
                      bfh_pkg::BFH_OP_LMASTER, bfh_pkg::BFH_OP_LCLEAR};
  endfunction : has_second

  function automatic logic alters(input bfh_pkg::bfh_op_t op);
    return op inside {bfh_pkg::BFH_OP_ERASE, bfh_pkg::BFH_OP_WRITE,
                      bfh_pkg::BFH_OP_LBLOCK, bfh_pkg::BFH_OP_LMASTER,
                      bfh_pkg::BFH_OP_LCLEAR};
  endfunction : alters

  function automatic logic is_read(
    input bfh_pkg::bfh_op_t op,
    input logic             second
  );
    return (op == bfh_pkg::BFH_OP_READ && !second) ||
           (op == bfh_pkg::BFH_OP_STATUS && second);
  endfunction : is_read

  assign take     = req_valid && req_ready_r;
  assign cyc_read = is_read(req_r.op, second_r);
  assign last_cyc = second_r || !has_second(req_r.op);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the far side runs on no clock of ours.

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rb_meta_r <= 1'b1;
      rb_sync_r <= 1'b1;
      dq_meta_r <= '0;
      dq_sync_r <= '0;
    end else begin
      rb_meta_r <= ready_busy_n;
      rb_sync_r <= rb_meta_r;
      dq_meta_r <= data_pins_i;
      dq_sync_r <= dq_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Phase pacing.

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_load_r <= 1'b1;
      tmr_cnt_r  <= TMR_W'(bfh_pkg::PD_CYC);
    end else begin
      tmr_load_r <= 1'b0;
      if (take && req.op == bfh_pkg::BFH_OP_PDOWN) begin
        tmr_load_r <= 1'b1;
        tmr_cnt_r  <= TMR_W'(bfh_pkg::PD_CYC);
      end else if (take) begin
        tmr_load_r <= 1'b1;
        tmr_cnt_r  <= TMR_W'(PHASE);
      end else if (tmr_done && st_r inside {BFH_SETUP, BFH_STRB}) begin
        tmr_load_r <= 1'b1;
        tmr_cnt_r  <= TMR_W'(PHASE);
      end else if (tmr_done && st_r == BFH_HOLD && !last_cyc) begin
        tmr_load_r <= 1'b1;
        tmr_cnt_r  <= TMR_W'(PHASE);
      end else if (tmr_done && st_r == BFH_PD) begin
        tmr_load_r <= 1'b1;
        tmr_cnt_r  <= TMR_W'(WAKE_CYC);
      end
    end
  end

  bfh_phase_timer #(
    .CNT_W (TMR_W)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (tmr_load_r),
    .count    (tmr_cnt_r),
    .done     (tmr_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus cycle sequencer and pins.

  // The memory is held in power-down while our own reset is low, so a
  // processor reset never finds it in a status mode.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r     <= BFH_PD;
      req_r    <= '0;
      second_r <= 1'b0;
      addr_r   <= '0;
      dout_r   <= '0;
      oe_r     <= 1'b0;
      ctl_r    <= '{chip_select_n:     1'b1,
                    output_gate_n:     1'b1,
                    write_strobe_n:    1'b1,
                    powerdown_reset_n: 1'b0};
    end else begin
      unique case (st_r)
        BFH_IDLE: begin
          if (take) begin
            req_r    <= req;
            second_r <= 1'b0;
            addr_r   <= req.addr;
            if (req.op == bfh_pkg::BFH_OP_PDOWN) begin
              ctl_r.powerdown_reset_n <= 1'b0;
              st_r                    <= BFH_PD;
            end else begin
              dout_r <= first_cmd(req.op);
              oe_r   <= !is_read(req.op, 1'b0);
              st_r   <= BFH_SETUP;
            end
          end
        end
        BFH_SETUP: begin
          if (tmr_done) begin
            ctl_r.chip_select_n <= 1'b0;
            if (cyc_read) begin
              ctl_r.output_gate_n <= 1'b0;
            end else begin
              ctl_r.write_strobe_n <= 1'b0;
            end
            st_r <= BFH_STRB;
          end
        end
        BFH_STRB: begin
          // Strobes rise before select so the write is latched by strobe.
          if (tmr_done) begin
            ctl_r.output_gate_n  <= 1'b1;
            ctl_r.write_strobe_n <= 1'b1;
            st_r                 <= BFH_HOLD;
          end
        end
        BFH_HOLD: begin
          if (tmr_done) begin
            ctl_r.chip_select_n <= 1'b1;
            oe_r                <= 1'b0;
            if (!last_cyc) begin
              second_r <= 1'b1;
              dout_r   <= second_cmd(req_r.op, req_r.data);
              oe_r     <= !is_read(req_r.op, 1'b1);
              st_r     <= BFH_SETUP;
            end else if (alters(req_r.op)) begin
              st_r <= BFH_POLL;
            end else begin
              st_r <= BFH_IDLE;
            end
          end
        end
        BFH_POLL: begin
          // No bound here: an operation may take as long as it takes.
          if (rb_sync_r) begin
            st_r <= BFH_IDLE;
          end
        end
        BFH_PD: begin
          if (tmr_done) begin
            ctl_r.powerdown_reset_n <= 1'b1;
            st_r                    <= BFH_WAKE;
          end
        end
        BFH_WAKE: begin
          if (tmr_done) begin
            st_r <= BFH_IDLE;
          end
        end
        default: begin
          st_r <= BFH_IDLE;
        end
      endcase
    end
  end

  a_read_no_strobe: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !(!ctl.output_gate_n && !ctl.write_strobe_n))
    else $error("Gate and strobe low together.");

  a_strobe_selected: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !ctl.write_strobe_n |-> !ctl.chip_select_n)
    else $error("Strobe low while deselected.");

  a_gate_selected: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !ctl.output_gate_n |-> !ctl.chip_select_n)
    else $error("Gate low while deselected.");

  a_pd_min_low: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $fell(ctl.powerdown_reset_n) |-> !ctl.powerdown_reset_n [*5])
    else $error("Power-down pulse too short.");

  a_wake_no_write: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(ctl.powerdown_reset_n) |-> ctl.write_strobe_n [*8])
    else $error("Write too soon after wake.");

  a_wake_no_read: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(ctl.powerdown_reset_n) |-> ctl.output_gate_n [*8])
    else $error("Read too soon after wake.");

  a_addr_held: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !ctl.chip_select_n |-> $stable(addr_pins))
    else $error("Address moved during a cycle.");

  a_pd_deselect: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !ctl.powerdown_reset_n |-> ctl.chip_select_n)
    else $error("Selected during power-down.");

  //////////////////////////////////////////////////////////////////////////////
  // Handshake and response.

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= '0;
      dev_busy_r  <= 1'b0;
    end else begin
      req_ready_r <= (st_r == BFH_IDLE) && !take;
      rsp_valid_r <= (st_r == BFH_HOLD) && tmr_done && last_cyc &&
                     cyc_read;
      if (st_r == BFH_STRB && tmr_done && cyc_read) begin
        rsp_data_r <= dq_sync_r;
      end
      dev_busy_r <= !rb_sync_r;
    end
  end

  assign req_ready    = req_ready_r;
  assign rsp_valid    = rsp_valid_r;
  assign rsp_data     = rsp_data_r;
  assign dev_busy     = dev_busy_r;
  assign ctl          = ctl_r;
  assign addr_pins    = addr_r;
  assign data_pins_o  = dout_r;
  assign data_pins_oe = oe_r;

endmodule : bfh_host

// *** bfh_phase_timer.sv ***
`timescale 1ns/1ns
// Down-counter that paces each bus phase; done pulses on expiry.
module bfh_phase_timer #(
  parameter int CNT_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_r;
  logic             run_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      run_r <= 1'b1;
    end else if (run_r) begin
      if (cnt_r == '0) begin
        run_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign done = run_r && (cnt_r == '0) && !load;

endmodule : bfh_phase_timer

// *** bfh_pkg.sv ***
// Notes on behaviour
// - Alterations use two command cycles.
// - Host writes read-mode command before reading. Only status reads do; a plain read uses the mode already set.
// - Read: select and gate low, strobe high.
// - Power-down needs reset low 100 ns.
// - Wake resets mode; host waits before reading.
// - Host waits after wake before writing.
// - Reset pin follows the processor reset.
// - Host supplies proper address per command.
package bfh_pkg;

  localparam int          ADDR_W         = 20;
  localparam int          DATA_W         = 8;
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          PD_MIN_NS      = 100;
  localparam int          PD_CYC         =
    (PD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PHASE_CYC      = 3;
  localparam logic [7:0]  CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0]  CMD_READ_ID    = 8'h90;
  localparam logic [7:0]  CMD_READ_STAT  = 8'h70;
  localparam logic [7:0]  CMD_CLR_STAT   = 8'h50;
  localparam logic [7:0]  CMD_ERASE      = 8'h20;
  localparam logic [7:0]  CMD_CONFIRM    = 8'hD0;
  localparam logic [7:0]  CMD_WRITE      = 8'h40;
  localparam logic [7:0]  CMD_WRITE_ALT  = 8'h10;
  localparam logic [7:0]  CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0]  CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0]  CMD_SET_BLOCK  = 8'h01;
  localparam logic [7:0]  CMD_SET_MASTER = 8'hF1;

  typedef enum logic [3:0] {
    BFH_OP_READ    = 4'h0,
    BFH_OP_ARRAY   = 4'h1,
    BFH_OP_ID      = 4'h2,
    BFH_OP_STATUS  = 4'h3,
    BFH_OP_CLEAR   = 4'h4,
    BFH_OP_ERASE   = 4'h5,
    BFH_OP_WRITE   = 4'h6,
    BFH_OP_SUSPEND = 4'h7,
    BFH_OP_RESUME  = 4'h8,
    BFH_OP_LBLOCK  = 4'h9,
    BFH_OP_LMASTER = 4'hA,
    BFH_OP_LCLEAR  = 4'hB,
    BFH_OP_PDOWN   = 4'hC
  } bfh_op_t;

  typedef struct packed {
    bfh_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } bfh_req_t;

  typedef struct packed {
    logic                chip_select_n;
    logic                output_gate_n;
    logic                write_strobe_n;
    logic                powerdown_reset_n;
  } bfh_ctl_t;

endpackage : bfh_pkg

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
  logic core_clk = 0, rstn = 0, req_valid = 0, req_ready, rsp_valid, busy;
  logic [19:0] ap;
  logic [7:0] dq_o, dq_i, rsp_data;
  logic oe, rb_n;
  bfh_pkg::bfh_req_t req = '0;
  bfh_pkg::bfh_ctl_t ctl;
  int fails = 0, check_count = 0, i;
  bfh_pkg::bfh_req_t rows [16] = '{
    '{bfh_pkg::BFH_OP_WRITE, 20'h00003, 8'hA5},
    '{bfh_pkg::BFH_OP_WRITE, 20'hF0007, 8'h5A},
    '{bfh_pkg::BFH_OP_STATUS, 20'h0, 8'h80},
    '{bfh_pkg::BFH_OP_ID, 20'h0, 8'h00},
    '{bfh_pkg::BFH_OP_CLEAR, 20'h0, 8'h00},
    '{bfh_pkg::BFH_OP_ERASE, 20'h30000, 8'h00},
    '{bfh_pkg::BFH_OP_SUSPEND, 20'h0, 8'h00},
    '{bfh_pkg::BFH_OP_RESUME, 20'h0, 8'h00},
    '{bfh_pkg::BFH_OP_LBLOCK, 20'h20000, 8'h00},
    '{bfh_pkg::BFH_OP_LMASTER, 20'h0, 8'h00},
    '{bfh_pkg::BFH_OP_LCLEAR, 20'h0, 8'h00},
    '{bfh_pkg::BFH_OP_ARRAY, 20'h0, 8'h00},
    '{bfh_pkg::BFH_OP_READ, 20'h00003, 8'hA5},
    '{bfh_pkg::BFH_OP_READ, 20'hF0007, 8'h5A},
    '{bfh_pkg::BFH_OP_PDOWN, 20'h0, 8'h00},
    '{bfh_pkg::BFH_OP_READ, 20'h00003, 8'hA5}};
  bfh_host dut (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .dev_busy(busy), .ctl(ctl), .addr_pins(ap),
    .data_pins_o(dq_o), .data_pins_oe(oe), .data_pins_i(dq_i),
    .ready_busy_n(rb_n));
  bfh_flash_model fm (.ctl(ctl), .addr_pins(ap), .data_pins_o(dq_o),
    .data_pins_i(dq_i), .ready_busy_n(rb_n));
  initial forever #10 core_clk = ~core_clk;
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_hi(ref logic s);
    int n;
    for (n = 0; s !== 1'b1; n++) begin
      if (n > 5000) begin
        fails++;
        report_and_stop;
      end
      @(posedge core_clk);
      #1;
    end
  endtask : wait_hi
  task send(input bfh_pkg::bfh_req_t r);
    @(posedge core_clk);
    #1 req = r;
    req_valid = 1;
    wait_hi(req_ready);
    @(posedge core_clk);
    #1 req_valid = 0;
    if (r.op inside {bfh_pkg::BFH_OP_READ, bfh_pkg::BFH_OP_STATUS}) begin
      wait_hi(rsp_valid);
      chk(rsp_data, r.data);
    end
  endtask : send
  initial begin
    repeat (4) @(posedge core_clk);
    #1 rstn = 1;
    for (i = 0; i < 16; i++) send(rows[i]);
    $display("table done");
    send('{bfh_pkg::BFH_OP_WRITE, 20'h00008, 8'h3C});
    wait_hi(busy);
    chk({7'h00, req_ready}, 8'h00);
    wait_hi(req_ready);
    chk({7'h00, busy}, 8'h00);
    send('{bfh_pkg::BFH_OP_ARRAY, 20'h0, 8'h00});
    send('{bfh_pkg::BFH_OP_READ, 20'h00008, 8'h3C});
    $display("busy test done");
    @(posedge core_clk);
    #1 rstn = 0;
    #1 chk({4'h0, ctl}, 8'h0E);
    repeat (2) @(posedge core_clk);
    #1 rstn = 1;
    send('{bfh_pkg::BFH_OP_READ, 20'h00003, 8'hA5});
    $display("reset test done");
    repeat (5) @(posedge core_clk);
    chk({7'h00, oe}, 8'h00);
    chk({4'h0, ctl}, 8'h0F);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, rsp_valid}, 8'h00);
    $display("idle pins done");
    report_and_stop;
  end
endmodule : tb
